// ==== logic/dpo_pkg.sv ====
// package for the debug pin override control block
// assumes a byte-addressed plain register port with 32-bit data
package dpo_pkg;
    localparam logic [31:0] DPO_ADDR_CONFIG     = 32'h4000BC00;
    localparam logic [31:0] DPO_ADDR_STATUS     = 32'h4000BC04;
    localparam logic [31:0] DPO_CONFIG_RESET    = 32'h00000010;
    localparam logic [31:0] DPO_STATUS_RESET    = 32'h00000000;
    localparam int          DPO_BIT_DEBUG_DIS   = 5;
    localparam int          DPO_BIT_REGEN       = 4;
    localparam int          DPO_BIT_CFG_RSVD    = 3;
    localparam int          DPO_BIT_BOOT        = 3;
    localparam int          DPO_BIT_FORCED      = 1;
    localparam int          DPO_BIT_SW_EN       = 0;
    localparam logic [31:0] DPO_CONFIG_WMASK    = 32'h00000038;

    typedef enum logic [1:0] {
        DPO_DBG_IDLE,
        DPO_DBG_ACTIVE,
        DPO_DBG_LOCKED
    } dpo_dbg_state_t;
endpackage : dpo_pkg

// ==== logic/dpo_boot_capture.sv ====
// boot strap capture at reset release
// assumes strap is stable around reset release
`timescale 1ns/100ps
`default_nettype none
module dpo_boot_capture
    import dpo_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // strap
    input  wire logic boot_strap_n,
    // result
    output logic      boot_strap_captured
);
    logic done_q;
    logic done_d;
    logic cap_q;
    logic cap_d;

    always_comb
    begin
        done_d = 1'b1;
        cap_d  = cap_q;
        if (!done_q)
        begin
            cap_d = ~boot_strap_n;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            done_q <= 1'b0;
            cap_q  <= 1'b0;
        end
        else
        begin
            done_q <= done_d;
            cap_q  <= cap_d;
        end
    end

    assign boot_strap_captured = cap_q;
endmodule : dpo_boot_capture
`default_nettype wire

// ==== logic/dpo_ctrl.sv ====
// debug pin override control and status registers
// assumes synchronous inputs, one clock, plain register port
`timescale 1ns/100ps
`default_nettype none
module dpo_ctrl
    import dpo_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // debug side
    input  wire logic        debug_request,
    input  wire logic        debugger_forced_in,
    input  wire logic        serial_wire_en_in,
    input  wire logic        reserved_set,
    input  wire logic        reserved_clr,
    input  wire logic        boot_strap_n,
    // pin control
    output logic             debug_active,
    output logic             port_a_pin_7_regen_sel
);
    // config register state
    logic           dis_q;
    logic           dis_d;
    logic           regen_q;
    logic           regen_d;
    logic           rsvd_q;
    logic           rsvd_d;
    // sampled status inputs
    logic           forced_q;
    logic           forced_d;
    logic           swen_q;
    logic           swen_d;
    // read data and debug state
    logic [31:0]    rdata_q;
    logic [31:0]    rdata_d;
    dpo_dbg_state_t st_q;
    dpo_dbg_state_t st_d;
    // decodes and helpers
    logic           boot_cap;
    logic           wr_cfg;
    logic           rd_cfg;
    logic           rd_stat;
    logic           rsvd_hw_hit;
    logic           wants_debug;

    dpo_boot_capture u_boot (
        .clk                 (clk),
        .sys_rst             (sys_rst),
        .boot_strap_n        (boot_strap_n),
        .boot_strap_captured (boot_cap)
    );

    assign wr_cfg      = reg_wr && (reg_addr == DPO_ADDR_CONFIG);
    assign rd_cfg      = reg_rd && (reg_addr == DPO_ADDR_CONFIG);
    assign rd_stat     = reg_rd && (reg_addr == DPO_ADDR_STATUS);
    // either hardware pulse takes the reserved bit this cycle
    assign rsvd_hw_hit = reserved_set || reserved_clr;
    // a forced cable counts as a request as well
    assign wants_debug = debug_request || debugger_forced_in;

    always_comb
    begin
        dis_d   = dis_q;
        regen_d = regen_q;
        rsvd_d  = rsvd_q;
        if (wr_cfg)
        begin
            dis_d   = reg_wdata[DPO_BIT_DEBUG_DIS];
            regen_d = reg_wdata[DPO_BIT_REGEN];
            rsvd_d  = reg_wdata[DPO_BIT_CFG_RSVD];
        end
        // hardware update wins over a software write, set beats clear
        if (rsvd_hw_hit)
        begin
            rsvd_d = reserved_set;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dis_q   <= DPO_CONFIG_RESET[DPO_BIT_DEBUG_DIS];
            regen_q <= DPO_CONFIG_RESET[DPO_BIT_REGEN];
            rsvd_q  <= DPO_CONFIG_RESET[DPO_BIT_CFG_RSVD];
        end
        else
        begin
            dis_q   <= dis_d;
            regen_q <= regen_d;
            rsvd_q  <= rsvd_d;
        end
    end

    // live status inputs, one register of delay
    always_comb
    begin
        forced_d = debugger_forced_in;
        swen_d   = serial_wire_en_in;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            forced_q <= DPO_STATUS_RESET[DPO_BIT_FORCED];
            swen_q   <= DPO_STATUS_RESET[DPO_BIT_SW_EN];
        end
        else
        begin
            forced_q <= forced_d;
            swen_q   <= swen_d;
        end
    end

    // idle: free to go active; active: held by the request alone;
    // locked: disable bit set while idle or when active ends, waits for it to clear
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            DPO_DBG_IDLE:
            begin
                if (dis_q)
                begin
                    st_d = DPO_DBG_LOCKED;
                end
                else if (wants_debug)
                begin
                    st_d = DPO_DBG_ACTIVE;
                end
            end
            DPO_DBG_ACTIVE:
            begin
                // already active: disable bit cannot drop it
                if (!wants_debug)
                begin
                    if (dis_q)
                    begin
                        st_d = DPO_DBG_LOCKED;
                    end
                    else
                    begin
                        st_d = DPO_DBG_IDLE;
                    end
                end
            end
            DPO_DBG_LOCKED:
            begin
                if (!dis_q)
                begin
                    st_d = DPO_DBG_IDLE;
                end
            end
            default:
            begin
                st_d = DPO_DBG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= DPO_DBG_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // read data for one cycle after the strobe, zero otherwise
    always_comb
    begin
        rdata_d = 32'h00000000;
        if (rd_cfg)
        begin
            rdata_d[DPO_BIT_DEBUG_DIS] = dis_q;
            rdata_d[DPO_BIT_REGEN]     = regen_q;
            rdata_d[DPO_BIT_CFG_RSVD]  = rsvd_q;
        end
        else if (rd_stat)
        begin
            rdata_d[DPO_BIT_BOOT]   = boot_cap;
            rdata_d[DPO_BIT_FORCED] = forced_q;
            rdata_d[DPO_BIT_SW_EN]  = swen_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_q <= 32'h00000000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata              = rdata_q;
    assign debug_active           = (st_q == DPO_DBG_ACTIVE);
    assign port_a_pin_7_regen_sel = regen_q;
endmodule : dpo_ctrl
`default_nettype wire

// ==== sim/dpo_cable.sv ====
// debugger cable model: puts the bench's wishes on the debug pins
// assumes one clock shared with the block
`timescale 1ns/100ps
`default_nettype none
module dpo_cable
(
    // bench side
    input  wire logic       clk,
    input  wire logic [2:0] want,
    // debug pins
    output logic            debug_request,
    output logic            debugger_forced_in,
    output logic            serial_wire_en_in
);
    always_ff @(posedge clk)
    begin
        {debug_request, debugger_forced_in, serial_wire_en_in} <= want;
    end
endmodule : dpo_cable
`default_nettype wire

// ==== sim/dpo_ctrl_properties.sv ====
// checker for the debug pin override block
// assumes one clock and the top's ports only
`timescale 1ns/100ps
`default_nettype none
module dpo_chk
    import dpo_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // debug side and pins
    input wire logic        debug_request,
    input wire logic        debugger_forced_in,
    input wire logic        serial_wire_en_in,
    input wire logic        debug_active,
    input wire logic        port_a_pin_7_regen_sel
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire logic cfg_wr = reg_wr && reg_addr == DPO_ADDR_CONFIG;
    wire logic st_rd  = reg_rd && reg_addr == DPO_ADDR_STATUS;
    wire logic cfg_rd = reg_rd && reg_addr == DPO_ADDR_CONFIG;
    wire logic want   = debug_request || debugger_forced_in;
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("rdata without read");
    AST_UNUSED: assert property ($past(reg_rd) |-> reg_rdata[31:6] == '0 && !reg_rdata[2])
        else $error("unused bit set");
    AST_SWEN: assert property ($past(st_rd) |-> reg_rdata[0] == $past(serial_wire_en_in, 2))
        else $error("serial wire bit");
    AST_FORCED: assert property ($past(st_rd) |-> reg_rdata[1] == $past(debugger_forced_in, 2))
        else $error("forced bit");
    AST_REGEN: assert property (cfg_wr |=> port_a_pin_7_regen_sel == $past(reg_wdata[4]))
        else $error("pin 7 select");
    AST_CFG_RD: assert property ($past(cfg_rd) |-> reg_rdata[4] == $past(port_a_pin_7_regen_sel))
        else $error("config read");
    AST_HOLD: assert property (debug_active && debug_request && $past(debug_request) |=> debug_active)
        else $error("debug dropped");
    AST_RISE: assert property ($rose(debug_active) |-> $past(want) || $past(want, 2))
        else $error("debug without request");
    cover property ($rose(debug_active));
    cover property (cfg_wr && reg_wdata[DPO_BIT_DEBUG_DIS]);
    cover property ($fell(port_a_pin_7_regen_sel));
endmodule : dpo_chk
bind dpo_ctrl dpo_chk u_chk (.*);
`default_nettype wire

// ==== sim/dpo_ctrl_tb.sv ====
// self-checking bench for the debug pin override block
// assumes the cable model and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module dpo_ctrl_tb
    import dpo_pkg::*;
    ();
    logic        clk, sys_rst, reg_wr, reg_rd, rsv_set, rsv_clr, strap_n;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0]  want;
    logic        dbg_req, dbg_frc, sw_en, dbg_act, pin7;
    int          n_mismatch, checks_done;
    dpo_ctrl uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_request(dbg_req),
        .debugger_forced_in(dbg_frc), .serial_wire_en_in(sw_en), .reserved_set(rsv_set),
        .reserved_clr(rsv_clr), .boot_strap_n(strap_n), .debug_active(dbg_act),
        .port_a_pin_7_regen_sel(pin7));
    dpo_cable u_cable (.clk(clk), .want(want), .debug_request(dbg_req),
        .debugger_forced_in(dbg_frc), .serial_wire_en_in(sw_en));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic close_out();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rst(input logic s);
        @(posedge clk);
        strap_n <= s;
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        strap_n <= ~s;
        #1;
    endtask : rst
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic hw(input logic s);
        @(posedge clk);
        {rsv_set, rsv_clr} <= {s, !s};
        @(posedge clk);
        {rsv_set, rsv_clr} <= 2'b00;
    endtask : hw
    task automatic dbg(input logic [2:0] w, input logic e);
        @(posedge clk);
        want <= w;
        repeat (4) @(posedge clk);
        #1;
        chk({31'h0, dbg_act}, {31'h0, e});
    endtask : dbg
    initial
    begin
        #20000;
        n_mismatch++;
        close_out();
    end
    initial
    begin
        {reg_wr, reg_rd, rsv_set, rsv_clr, reg_addr, reg_wdata, want} = '0;
        {n_mismatch, checks_done, strap_n} = '0;
        sys_rst = 1'b1;
        rst(1'b0);
        chk({31'h0, pin7}, 32'h1);
        rd(DPO_ADDR_CONFIG, DPO_CONFIG_RESET);
        wr(DPO_ADDR_STATUS, 32'hFFFFFFFF);
        rd(DPO_ADDR_STATUS, 32'h8);
        wr(DPO_ADDR_CONFIG, 32'hFFFFFFC7);
        rd(DPO_ADDR_CONFIG, 32'h0);
        chk({31'h0, pin7}, 32'h0);
        hw(1'b1);
        rd(DPO_ADDR_CONFIG, 32'h8);
        wr(DPO_ADDR_CONFIG, 32'h18);
        rd(DPO_ADDR_CONFIG, 32'h18);
        hw(1'b0);
        rd(DPO_ADDR_CONFIG, 32'h10);
        dbg(3'b100, 1'b1);
        wr(DPO_ADDR_CONFIG, 32'h30);
        dbg(3'b100, 1'b1);
        dbg(3'b000, 1'b0);
        dbg(3'b100, 1'b0);
        wr(DPO_ADDR_CONFIG, 32'h10);
        dbg(3'b100, 1'b1);
        dbg(3'b011, 1'b1);
        rd(DPO_ADDR_STATUS, 32'hB);
        dbg(3'b000, 1'b0);
        rd(DPO_ADDR_STATUS, 32'h8);
        rd(32'h4000BC08, 32'h0);
        rst(1'b1);
        rd(DPO_ADDR_STATUS, 32'h0);
        close_out();
    end
endmodule : dpo_ctrl_tb
`default_nettype wire
